/* core/pced_edge.sv */
// ----------------------------------------
// pin edge detector
// ----------------------------------------
module pced_edge #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // pins and pulses
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] prev_q;
   logic [2:0]   fill_q;

   // two-stage sync then previous sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q     <= '0;
         s2_q     <= '0;
         prev_q   <= '0;
         fill_q   <= '0;
      end else begin
         s1_q     <= pin;
         s2_q     <= s1_q;
         prev_q   <= s2_q;
         fill_q   <= {fill_q[1:0], 1'b1};
      end
   end

   // one-cycle pulses per transition, held off until prev_q holds a real sample
   // so that a pin resting high gives no false edge after reset
   assign rise = fill_q[2] ? (s2_q & ~prev_q) : '0;
   assign fall = fill_q[2] ? (~s2_q & prev_q) : '0;
endmodule

/* core/pced_pkg.sv */
package pced_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_B_RISE  = 8'h00;
   localparam logic [7:0] OFS_B_FALL  = 8'h04;
   localparam logic [7:0] OFS_B_FLAG  = 8'h08;
   localparam logic [7:0] OFS_C_RISE  = 8'h0c;
   localparam logic [7:0] OFS_C_FALL  = 8'h10;
   localparam logic [7:0] OFS_C_FLAG  = 8'h14;
   localparam logic [7:0] OFS_E_RISE  = 8'h18;
   localparam logic [7:0] OFS_E_FALL  = 8'h1c;
   localparam logic [7:0] OFS_E_FLAG  = 8'h20;
   localparam logic [7:0] OFS_CTRL    = 8'h24;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h28;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h2c;
   // implemented-bit masks
   localparam logic [7:0] MASK_B      = 8'hff;
   localparam logic [7:0] MASK_C      = 8'hdf;
   localparam logic [7:0] MASK_E      = 8'h08;
   // control register fields
   localparam int         CTRL_IE_BIT = 0;
   localparam int         CTRL_XR_BIT = 1;
   localparam int         CTRL_LV_BIT = 2;
   // irq status bit: summary change
   localparam int         IRQ_SUM_BIT = 0;
   localparam logic [7:0] RESET_VAL   = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* core/pced_top.sv */
// Functional notes
// - port b rising enable makes rising edge set pin flag and summary
// - port b falling enable makes falling edge set flags; clear disables
// - port b flag set on enabled rise or enabled fall; both catch either
// - flags read/write by software, cleared by writing zero
// - port c rising enables on bits 7-6,4-0; bit 5 reads zero
// - port c falling enables on bits 7-6,4-0; bit 5 reads zero
// - port c flags bits 7-6,4-0 set on enabled edges
// - port e rising enable only on bit 3, others read zero
// - reset-pin or low-voltage-programming enable disables port e pin 3 detection
// - detection continues with master enable clear; only interrupt suppressed (irq still raised from sticky status when its mask is set)
// - edge during flag write leaves flag set
// - summary flag is or of all pin flags
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
module pced_top (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pins
   input  wire logic [7:0]  port_b_pin,
   input  wire logic [7:0]  port_c_pin,
   input  wire logic        port_e_pin3,
   // outputs to core
   output logic             summary_change_flag,
   output logic             irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]  b_rise_q, b_fall_q, b_flag_q, b_flag_d;
   logic [7:0]  c_rise_q, c_fall_q, c_flag_q, c_flag_d;
   logic [7:0]  e_rise_q, e_fall_q, e_flag_q, e_flag_d;
   logic [2:0]  ctrl_q;
   logic        ist_q, ist_d, imsk_q;
   logic [7:0]  aw_q, ar_q;
   logic        aw_have_q, w_have_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   logic        sum_flag;

   // ----------------------------------------
   // edge detection
   // ----------------------------------------
   logic [16:0] pins_all, rise_all, fall_all;
   assign pins_all = {port_e_pin3, port_c_pin, port_b_pin};

   pced_edge #(.W(17)) u_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (pins_all),
      .rise    (rise_all),
      .fall    (fall_all)
   );

   // enabled-edge hits per port
   logic [7:0] b_hit, c_hit, e_hit;
   logic       e_off;
   assign e_off = ctrl_q[pced_pkg::CTRL_XR_BIT] | ctrl_q[pced_pkg::CTRL_LV_BIT];
   assign b_hit = (rise_all[7:0] & b_rise_q) | (fall_all[7:0] & b_fall_q);
   assign c_hit = ((rise_all[15:8] & c_rise_q) | (fall_all[15:8] & c_fall_q)) & pced_pkg::MASK_C;
   assign e_hit = e_off ? 8'h00 : ({4'h0, rise_all[16] & e_rise_q[3], 3'h0}
                                  | {4'h0, fall_all[16] & e_fall_q[3], 3'h0});

   // ----------------------------------------
   // axi write path
   // ----------------------------------------
   // mapped, word-aligned register address
   function automatic logic addr_ok(input logic [7:0] a);
      return a <= pced_pkg::OFS_IRQ_MSK && a[1:0] == 2'b00;
   endfunction

   logic       wr_go, rd_go;
   logic [7:0] wbyte;
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wbyte = w_q[7:0];

   logic wr_b_rise, wr_b_fall, wr_b_flag, wr_c_rise, wr_c_fall, wr_c_flag;
   logic wr_e_rise, wr_e_fall, wr_e_flag, wr_ctrl, wr_ist, wr_imsk, wr_ok, wr_lane;
   assign wr_lane   = wr_go && ws_q[0];
   assign wr_b_rise = wr_lane && aw_q == pced_pkg::OFS_B_RISE;
   assign wr_b_fall = wr_lane && aw_q == pced_pkg::OFS_B_FALL;
   assign wr_b_flag = wr_lane && aw_q == pced_pkg::OFS_B_FLAG;
   assign wr_c_rise = wr_lane && aw_q == pced_pkg::OFS_C_RISE;
   assign wr_c_fall = wr_lane && aw_q == pced_pkg::OFS_C_FALL;
   assign wr_c_flag = wr_lane && aw_q == pced_pkg::OFS_C_FLAG;
   assign wr_e_rise = wr_lane && aw_q == pced_pkg::OFS_E_RISE;
   assign wr_e_fall = wr_lane && aw_q == pced_pkg::OFS_E_FALL;
   assign wr_e_flag = wr_lane && aw_q == pced_pkg::OFS_E_FLAG;
   assign wr_ctrl   = wr_lane && aw_q == pced_pkg::OFS_CTRL;
   assign wr_ist    = wr_lane && aw_q == pced_pkg::OFS_IRQ_ST;
   assign wr_imsk   = wr_lane && aw_q == pced_pkg::OFS_IRQ_MSK;
   assign wr_ok     = addr_ok(aw_q);

   // flag next values: hardware set wins over software write
   assign b_flag_d = (wr_b_flag ? (wbyte & pced_pkg::MASK_B) : b_flag_q) | b_hit;
   assign c_flag_d = (wr_c_flag ? (wbyte & pced_pkg::MASK_C) : c_flag_q) | c_hit;
   assign e_flag_d = (wr_e_flag ? (wbyte & pced_pkg::MASK_E) : e_flag_q) | e_hit;

   // summary event: sticky interrupt status, write one clears, set wins
   logic any_hit;
   assign any_hit = |{b_hit, c_hit, e_hit};
   assign ist_d = (ist_q & ~(wr_ist & wbyte[pced_pkg::IRQ_SUM_BIT])) | any_hit;

   // address/data capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_q         <= 8'h00;
         w_q          <= 32'h0;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pced_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_q      <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? pced_pkg::RESP_OKAY : pced_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // enables and control, unimplemented bits held at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_rise_q <= pced_pkg::RESET_VAL;
         b_fall_q <= pced_pkg::RESET_VAL;
         c_rise_q <= pced_pkg::RESET_VAL;
         c_fall_q <= pced_pkg::RESET_VAL;
         e_rise_q <= pced_pkg::RESET_VAL;
         e_fall_q <= pced_pkg::RESET_VAL;
         ctrl_q   <= 3'h0;
         imsk_q   <= 1'b0;
      end else begin
         if (wr_b_rise) b_rise_q <= wbyte & pced_pkg::MASK_B;
         if (wr_b_fall) b_fall_q <= wbyte & pced_pkg::MASK_B;
         if (wr_c_rise) c_rise_q <= wbyte & pced_pkg::MASK_C;
         if (wr_c_fall) c_fall_q <= wbyte & pced_pkg::MASK_C;
         if (wr_e_rise) e_rise_q <= wbyte & pced_pkg::MASK_E;
         if (wr_e_fall) e_fall_q <= wbyte & pced_pkg::MASK_E;
         if (wr_ctrl)   ctrl_q   <= wbyte[2:0];
         if (wr_imsk)   imsk_q   <= wbyte[pced_pkg::IRQ_SUM_BIT];
      end
   end

   // flags update regardless of master enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_flag_q <= pced_pkg::RESET_VAL;
         c_flag_q <= pced_pkg::RESET_VAL;
         e_flag_q <= pced_pkg::RESET_VAL;
         ist_q    <= 1'b0;
      end else begin
         b_flag_q <= b_flag_d;
         c_flag_q <= c_flag_d;
         e_flag_q <= e_flag_d;
         ist_q    <= ist_d;
      end
   end

   // summary flag and interrupt outputs
   assign sum_flag = |{b_flag_q, c_flag_q, e_flag_q};
   assign summary_change_flag = sum_flag;
   assign irq = (sum_flag & ctrl_q[pced_pkg::CTRL_IE_BIT]) | (ist_q & imsk_q);

   // ----------------------------------------
   // axi read path
   // ----------------------------------------
   logic [7:0] rd_val;
   logic       rd_ok;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_ok = addr_ok(s_axi_araddr);
   always_comb begin
      unique case (s_axi_araddr)
         pced_pkg::OFS_B_RISE:  rd_val = b_rise_q;
         pced_pkg::OFS_B_FALL:  rd_val = b_fall_q;
         pced_pkg::OFS_B_FLAG:  rd_val = b_flag_q;
         pced_pkg::OFS_C_RISE:  rd_val = c_rise_q;
         pced_pkg::OFS_C_FALL:  rd_val = c_fall_q;
         pced_pkg::OFS_C_FLAG:  rd_val = c_flag_q;
         pced_pkg::OFS_E_RISE:  rd_val = e_rise_q;
         pced_pkg::OFS_E_FALL:  rd_val = e_fall_q;
         pced_pkg::OFS_E_FLAG:  rd_val = e_flag_q;
         pced_pkg::OFS_CTRL:    rd_val = {5'h0, ctrl_q};
         pced_pkg::OFS_IRQ_ST:  rd_val = {7'h0, ist_q};
         pced_pkg::OFS_IRQ_MSK: rd_val = {7'h0, imsk_q};
         default:               rd_val = 8'h00;
      endcase
   end

   // read data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= pced_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h0, rd_val};
         s_axi_rresp  <= rd_ok ? pced_pkg::RESP_OKAY : pced_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // flag setting per port
   a_b_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      |b_hit |=> |b_flag_q) else $error("port b flag not set");
   a_b_rise_set: assert property (@(posedge aclk) disable iff (!aresetn)
      |(rise_all[7:0] & b_rise_q) |=> |b_flag_q && summary_change_flag) else $error("port b rise lost");
   a_b_fall_set: assert property (@(posedge aclk) disable iff (!aresetn)
      |(fall_all[7:0] & b_fall_q) |=> |b_flag_q && summary_change_flag) else $error("port b fall lost");
   a_c_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      |c_hit |=> (c_flag_q & $past(c_hit)) == $past(c_hit)) else $error("port c flag not set");
   a_e_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      e_hit[3] |=> e_flag_q[3]) else $error("port e flag not set");

   // unimplemented bits stay zero
   a_c_bit5_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !c_rise_q[5] && !c_fall_q[5] && !c_flag_q[5]) else $error("port c bit 5 set");
   a_e_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (e_rise_q & ~pced_pkg::MASK_E) == 8'h00) else $error("port e spare bit set");

   // software writes against hardware sets
   a_e_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      e_off && !wr_e_flag |=> $stable(e_flag_q)) else $error("port e flag moved while off");
   a_flag_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_c_flag && |c_hit |=> (c_flag_q & $past(c_hit)) == $past(c_hit)) else $error("edge lost");
   a_b_edge_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_b_flag && |b_hit |=> (b_flag_q & $past(b_hit)) == $past(b_hit)) else $error("port b edge lost");
   a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_b_flag && b_hit == 8'h00 |=> b_flag_q == ($past(wbyte) & pced_pkg::MASK_B)) else $error("flag write lost");

   // summary and interrupt
   a_sum_or: assert property (@(posedge aclk) disable iff (!aresetn)
      |b_flag_q |-> summary_change_flag) else $error("summary missing");
   a_sum_other: assert property (@(posedge aclk) disable iff (!aresetn)
      |{c_flag_q, e_flag_q} |-> summary_change_flag) else $error("summary missing other port");
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_q[pced_pkg::CTRL_IE_BIT] && !imsk_q |-> !irq) else $error("irq leaked");
   a_irq_master: assert property (@(posedge aclk) disable iff (!aresetn)
      summary_change_flag && ctrl_q[pced_pkg::CTRL_IE_BIT] |-> irq) else $error("irq not raised");
   a_irq_status: assert property (@(posedge aclk) disable iff (!aresetn)
      ist_q && imsk_q |-> irq) else $error("status irq not raised");

   // edge detector
   a_pulse_one: assert property (@(posedge aclk) disable iff (!aresetn)
      rise_all[0] |=> !rise_all[0]) else $error("rise pulse too long");
   a_quiet_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> (rise_all == 17'h0 && fall_all == 17'h0) [*3]) else $error("edge after reset");

   // ----------------------------------------
   // cover points
   // ----------------------------------------
   c_b_edge: cover property (@(posedge aclk) disable iff (!aresetn) |b_hit);
   c_flag_clear: cover property (@(posedge aclk) disable iff (!aresetn) wr_b_flag && wbyte == 8'h00);
   c_irq_up: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
   c_edge_on_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_b_flag && |b_hit);
   c_e_blocked: cover property (@(posedge aclk) disable iff (!aresetn) e_off && rise_all[16]);
endmodule

/* verif/pced_pin_model.sv */
// ----------------------------------------
// external pin levels of ports b, c and e
// ----------------------------------------
module pced_pin_model (
   // pin levels seen by the block
   output logic [7:0] port_b_pin,
   output logic [7:0] port_c_pin,
   output logic       port_e_pin3
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins rest low until the bench moves them
   initial begin
      port_b_pin  = 8'h00;
      port_c_pin  = 8'h00;
      port_e_pin3 = 1'b0;
   end

   // new levels land by non-blocking update off the calling edge
   task automatic drive(input logic [7:0] b, input logic [7:0] c, input logic e);
      port_b_pin  <= b;
      port_c_pin  <= c;
      port_e_pin3 <= e;
   endtask
endmodule

/* verif/tb.sv */
// ----------------------------------------
// self-checking bench for the pin change block
// ----------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, port_e_pin3, summary_change_flag, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, port_b_pin, port_c_pin;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          miscompares, tests_run, cycles;

   pced_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .port_b_pin, .port_c_pin, .port_e_pin3, .summary_change_flag, .irq);
   pced_pin_model pins (.port_b_pin, .port_c_pin, .port_e_pin3);

   // 100 mhz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // write cycle: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                     input logic [1:0] r = 2'b00);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      chk(s_axi_bresp, r, "bresp");
   endtask

   // read cycle with data and response compare
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      chk(s_axi_rdata, e, "rdata");
      chk(s_axi_rresp, r, "rresp");
   endtask

   // flags expected from one pin step under the given enables
   function automatic logic [7:0] efl(input logic [7:0] o, n, r, f, m);
      return ((~o & n & r) | (o & ~n & f)) & m;
   endfunction

   initial begin
      logic [7:0] rb, fb, rc, fc, nb, nc, ob, oc, eb, ec;
      int         seed;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
      {ob, oc} = 16'h0000;
      seed = $urandom(32'hd7d5);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // reset values and an unmapped place
      for (int a = 0; a <= 44; a += 4) rd(8'(a), 32'h0);
      rd(8'h30, 32'h0, pced_pkg::RESP_SLVERR);
      rd(8'h02, 32'h0, pced_pkg::RESP_SLVERR);
      wr(8'h30, 32'hff, 4'hf, pced_pkg::RESP_SLVERR);
      // implemented bits only; empty strobe stores nothing
      wr(pced_pkg::OFS_C_RISE, 32'hff);
      rd(pced_pkg::OFS_C_RISE, 32'(pced_pkg::MASK_C));
      wr(pced_pkg::OFS_C_FALL, 32'hff);
      rd(pced_pkg::OFS_C_FALL, 32'(pced_pkg::MASK_C));
      wr(pced_pkg::OFS_E_RISE, 32'hff);
      rd(pced_pkg::OFS_E_RISE, 32'(pced_pkg::MASK_E));
      wr(pced_pkg::OFS_B_RISE, 32'hff, 4'h0);
      rd(pced_pkg::OFS_B_RISE, 32'h0);
      // random enables and pin steps, first two hand-picked
      for (int i = 0; i < 24; i++) begin
         {rb, fb, rc, fc, nb, nc} = {16'($urandom()), 16'($urandom()), 16'($urandom())};
         if (i < 2) {rb, fb, rc, fc, nb, nc} = {{4{i[0] ? 8'hff : 8'h00}}, ~ob, ~oc};
         wr(pced_pkg::OFS_B_RISE, 32'(rb));
         wr(pced_pkg::OFS_B_FALL, 32'(fb));
         wr(pced_pkg::OFS_C_RISE, 32'(rc));
         wr(pced_pkg::OFS_C_FALL, 32'(fc));
         pins.drive(nb, nc, 1'b0);
         repeat (5) @(posedge aclk);
         eb = efl(ob, nb, rb, fb, pced_pkg::MASK_B);
         ec = efl(oc, nc, rc, fc, pced_pkg::MASK_C);
         chk(32'(summary_change_flag), 32'(|{eb, ec}), "summary");
         chk(32'(irq), 32'h0, "irq masked");
         rd(pced_pkg::OFS_B_FLAG, 32'(eb));
         rd(pced_pkg::OFS_C_FLAG, 32'(ec));
         wr(pced_pkg::OFS_B_FLAG, 32'h0);
         wr(pced_pkg::OFS_C_FLAG, 32'h0);
         rd(pced_pkg::OFS_B_FLAG, 32'h0);
         {ob, oc} = {nb, nc};
      end
      // edge before, with and after a clearing write: only the later write clears
      wr(pced_pkg::OFS_B_FALL, 32'hff);
      wr(pced_pkg::OFS_B_RISE, 32'hff);
      for (int k = 0; k < 3; k++) begin
         ob = ~ob;
         pins.drive(ob, oc, 1'b0);
         repeat (k) @(posedge aclk);
         wr(pced_pkg::OFS_B_FLAG, 32'h0);
         repeat (5) @(posedge aclk);
         rd(pced_pkg::OFS_B_FLAG, k == 2 ? 32'h0 : 32'hff);
         wr(pced_pkg::OFS_B_FLAG, 32'h0);
      end
      // port e pin blocked by either pin-function setting
      for (int cx = 0; cx < 4; cx++) begin
         wr(pced_pkg::OFS_CTRL, 32'(cx << 1));
         pins.drive(ob, oc, 1'b1);
         repeat (5) @(posedge aclk);
         rd(pced_pkg::OFS_E_FLAG, cx == 0 ? 32'h08 : 32'h0);
         pins.drive(ob, oc, 1'b0);
         repeat (5) @(posedge aclk);
         wr(pced_pkg::OFS_E_FLAG, 32'h0);
      end
      // port e falling edge, rise flag cleared first
      wr(pced_pkg::OFS_CTRL, 32'h0);
      wr(pced_pkg::OFS_E_FALL, 32'hff);
      rd(pced_pkg::OFS_E_FALL, 32'(pced_pkg::MASK_E));
      pins.drive(ob, oc, 1'b1);
      repeat (5) @(posedge aclk);
      wr(pced_pkg::OFS_E_FLAG, 32'h0);
      pins.drive(ob, oc, 1'b0);
      repeat (5) @(posedge aclk);
      rd(pced_pkg::OFS_E_FLAG, 32'h08);
      wr(pced_pkg::OFS_E_FLAG, 32'h0);
      // sticky status, mask and master enable
      rd(pced_pkg::OFS_IRQ_ST, 32'h1);
      wr(pced_pkg::OFS_IRQ_MSK, 32'h1);
      chk(32'(irq), 32'h1, "irq status");
      wr(pced_pkg::OFS_IRQ_ST, 32'h1);
      rd(pced_pkg::OFS_IRQ_ST, 32'h0);
      chk(32'(irq), 32'h0, "irq cleared");
      wr(pced_pkg::OFS_IRQ_MSK, 32'h0);
      wr(pced_pkg::OFS_CTRL, 32'h1);
      pins.drive(~ob, oc, 1'b0);
      repeat (5) @(posedge aclk);
      chk(32'(irq), 32'h1, "irq enabled");
      wr(pced_pkg::OFS_B_FLAG, 32'h0);
      chk(32'(irq), 32'h0, "irq flags clear");
      stop_test();
   end
endmodule
